// [mpfs_pkg.sv]
// Package with constants and types for the pause request and fault status slice
package mpfs_pkg;
  // ------------------------------------------------------------
  // Class layout
  // ------------------------------------------------------------
  localparam int            NUM_CLASS   = 9;
  localparam int            GLOBAL_IDX  = 8;
  localparam int            QUANTA_W    = 16;
  localparam int            IDX_W       = 4;
  // ------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------
  localparam logic [15:0]   TIMER_RST   = 16'h0000;
  localparam logic [8:0]    MASK_RST    = 9'h000;
  localparam logic [3:0]    IDX_RST     = 4'h0;
  localparam int            CLK_PERIOD_NS = 8;
  // Pause quanta timer ticks: this many ns per refresh unit, floored to whole clock cycles (512 bit times at 40G is about 12.8 ns)
  localparam real           QUANTUM_NS  = 12.8;
  localparam int            QUANTUM_CYC_RAW = int'($floor(QUANTUM_NS / CLK_PERIOD_NS));
  localparam int            QUANTUM_CYC = (QUANTUM_CYC_RAW < 1) ? 1 : QUANTUM_CYC_RAW;
  localparam logic [3:0]    TICK_MAX    = 4'(QUANTUM_CYC - 1);

  // Transmit arbitration states
  typedef enum logic [1:0] {
    MPFS_IDLE = 2'b00,
    MPFS_WAIT = 2'b01,
    MPFS_SEND = 2'b10
  } mpfs_state_t;
endpackage : mpfs_pkg

// [mpfs_fault_status.sv]
// Registered receive fault status outputs
`timescale 1ns/1ps
`default_nettype none
module mpfs_fault_status (
  // Clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Fault causes from the receive path
  input  wire logic remote_fault_det,
  input  wire logic test_pattern_gen,
  input  wire logic lane_align_bad,
  input  wire logic hi_ber,
  input  wire logic rx_lf_fsm_fault,
  // Status levels
  output logic      remote_fault_ff,
  output logic      internal_local_fault_ff,
  output logic      received_local_fault_ff,
  output logic      local_fault_ff
);
  logic nxt_remote_fault;
  logic nxt_internal_local_fault;
  logic nxt_received_local_fault;
  logic nxt_local_fault;

  // Levels follow their causes; no latching, so they drop as soon as the cause clears
  always_comb begin
    nxt_remote_fault         = remote_fault_det;
    nxt_internal_local_fault = test_pattern_gen | lane_align_bad | hi_ber;
    nxt_received_local_fault = rx_lf_fsm_fault;
    nxt_local_fault          = nxt_internal_local_fault | nxt_received_local_fault;
  end

  // Register all levels together so the combined flag never leads its parts
  always_ff @(posedge clk) begin
    if (rst) begin
      remote_fault_ff         <= 1'b0;
      internal_local_fault_ff <= 1'b0;
      received_local_fault_ff <= 1'b0;
      local_fault_ff          <= 1'b0;
    end else if (ce) begin
      remote_fault_ff         <= nxt_remote_fault;
      internal_local_fault_ff <= nxt_internal_local_fault;
      received_local_fault_ff <= nxt_received_local_fault;
      local_fault_ff          <= nxt_local_fault;
    end
  end

  a_local_fault_or: assert property (@(posedge clk) disable iff (rst)
    local_fault_ff == (internal_local_fault_ff | received_local_fault_ff))
    else $error("combined local fault mismatch");
  a_internal_cause: assert property (@(posedge clk) disable iff (rst)
    ce |=> internal_local_fault_ff == $past(test_pattern_gen | lane_align_bad | hi_ber))
    else $error("internal local fault not following cause");
  a_remote_level: assert property (@(posedge clk) disable iff (rst)
    ce |=> remote_fault_ff == $past(remote_fault_det))
    else $error("remote fault level wrong");
  a_received_level: assert property (@(posedge clk) disable iff (rst)
    ce |=> received_local_fault_ff == $past(rx_lf_fsm_fault))
    else $error("received local fault level wrong");
endmodule : mpfs_fault_status
`default_nettype wire

// [mpfs_top.sv]
// Pause frame request scheduler with fault status outputs
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Remote fault output is a level
// - Internal local fault from pattern, alignment, BER
// - Received local fault while partner fault persists
// - Local fault is OR of both
// - Each set request bit sends a pause
// - Pause carries quanta of its own index
// - Nine 16-bit quanta, index 8 global
// - Cleared enable bit blocks that class
// - Resend reissues pauses for every requested and enabled class, resets timers
// - Nine refresh timers set retransmit interval
module mpfs_top (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Pause controls from user logic
  input  wire logic [8:0]  pause_req,
  input  wire logic [8:0]  pause_enable,
  input  wire logic        resend_pause,
  input  wire logic [15:0] pause_quanta [9],
  input  wire logic [15:0] pause_refresh_timer [9],
  // Frame activity of the transmit path
  input  wire logic        tx_frame_busy,
  input  wire logic        pause_done,
  // Pause frame command to the formatter
  output logic             pause_send_ff,
  output logic             pause_global_ff,
  output logic [3:0]       pause_index_ff,
  output logic [15:0]      pause_quanta_ff,
  output logic [8:0]       pause_pending_ff,
  // Fault causes
  input  wire logic        remote_fault_det,
  input  wire logic        test_pattern_gen,
  input  wire logic        lane_align_bad,
  input  wire logic        hi_ber,
  input  wire logic        rx_lf_fsm_fault,
  // Fault status
  output logic             remote_fault_ff,
  output logic             internal_local_fault_ff,
  output logic             received_local_fault_ff,
  output logic             local_fault_ff
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  mpfs_pkg::mpfs_state_t state_ff, nxt_state;
  logic [8:0]  nxt_pending;
  logic [15:0] timer_ff [9];
  logic [15:0] nxt_timer [9];
  logic [3:0]  tick_ff, nxt_tick;
  logic        tick;
  logic [8:0]  expire;
  logic [3:0]  pick;
  logic        pick_vld;
  logic        nxt_send;
  logic        nxt_global;
  logic [3:0]  nxt_index;
  logic [15:0] nxt_quanta;
  logic        active;

  assign tick = (tick_ff == mpfs_pkg::TICK_MAX);

  // Quantum tick prescaler shared by all refresh timers
  always_comb begin
    nxt_tick = tick ? 4'h0 : 4'(tick_ff + 4'h1);
  end

  // ------------------------------------------------------------
  // Per-class refresh timers
  // ------------------------------------------------------------
  // A class re-arms when its timer runs out while request and enable stay high
  genvar g;
  generate
    for (g = 0; g < mpfs_pkg::NUM_CLASS; g++) begin : g_cls
      logic act;
      assign act = pause_req[g] & pause_enable[g];
      assign expire[g] = act && (timer_ff[g] == 16'h0000) && !pause_pending_ff[g];
      always_comb begin
        nxt_timer[g] = timer_ff[g];
        if (!act || resend_pause) begin
          nxt_timer[g] = mpfs_pkg::TIMER_RST;
        end else if (nxt_send && nxt_index == 4'(g)) begin
          nxt_timer[g] = pause_refresh_timer[g];
        end else if (tick && timer_ff[g] != 16'h0000) begin
          nxt_timer[g] = 16'(timer_ff[g] - 16'h0001);
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          timer_ff[g] <= mpfs_pkg::TIMER_RST;
        end else if (ce) begin
          timer_ff[g] <= nxt_timer[g];
        end
      end
    end
  endgenerate

  // Lowest index wins; global class is index 8 and therefore yields to priorities
  always_comb begin
    pick     = mpfs_pkg::IDX_RST;
    pick_vld = 1'b0;
    for (int i = mpfs_pkg::NUM_CLASS - 1; i >= 0; i--) begin
      if (pause_pending_ff[i] && pause_enable[i]) begin
        pick     = 4'(i);
        pick_vld = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Scheduler
  // ------------------------------------------------------------
  // Pending set wins over the clear of a sent class so no request is lost
  always_comb begin
    nxt_state  = state_ff;
    nxt_send   = 1'b0;
    nxt_global = pause_global_ff;
    nxt_index  = pause_index_ff;
    nxt_quanta = pause_quanta_ff;
    nxt_pending = pause_pending_ff & pause_enable & pause_req;
    case (state_ff)
      mpfs_pkg::MPFS_IDLE: begin
        if (pick_vld) begin
          nxt_state = mpfs_pkg::MPFS_WAIT;
        end
      end
      mpfs_pkg::MPFS_WAIT: begin
        if (!pick_vld) begin
          nxt_state = mpfs_pkg::MPFS_IDLE;
        end else if (!tx_frame_busy) begin
          nxt_state  = mpfs_pkg::MPFS_SEND;
          nxt_send   = 1'b1;
          nxt_index  = pick;
          nxt_global = (pick == 4'(mpfs_pkg::GLOBAL_IDX));
          nxt_quanta = pause_quanta[pick];
          nxt_pending[pick] = 1'b0;
        end
      end
      mpfs_pkg::MPFS_SEND: begin
        if (pause_done) begin
          nxt_state = mpfs_pkg::MPFS_IDLE;
        end
      end
      default: begin
        nxt_state = mpfs_pkg::MPFS_IDLE;
      end
    endcase
    // Resend marks every active class pending for the next gap
    if (resend_pause) begin
      nxt_pending = nxt_pending | (pause_req & pause_enable);
    end
    nxt_pending = nxt_pending | expire;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff         <= mpfs_pkg::MPFS_IDLE;
      pause_send_ff    <= 1'b0;
      pause_global_ff  <= 1'b0;
      pause_index_ff   <= mpfs_pkg::IDX_RST;
      pause_quanta_ff  <= mpfs_pkg::TIMER_RST;
      pause_pending_ff <= mpfs_pkg::MASK_RST;
      tick_ff          <= 4'h0;
    end else if (ce) begin
      state_ff         <= nxt_state;
      pause_send_ff    <= nxt_send;
      pause_global_ff  <= nxt_global;
      pause_index_ff   <= nxt_index;
      pause_quanta_ff  <= nxt_quanta;
      pause_pending_ff <= nxt_pending;
      tick_ff          <= nxt_tick;
    end
  end

  // ------------------------------------------------------------
  // Fault status
  // ------------------------------------------------------------
  mpfs_fault_status u_fault (
    .clk                     (clk),
    .rst                     (rst),
    .ce                      (ce),
    .remote_fault_det        (remote_fault_det),
    .test_pattern_gen        (test_pattern_gen),
    .lane_align_bad          (lane_align_bad),
    .hi_ber                  (hi_ber),
    .rx_lf_fsm_fault         (rx_lf_fsm_fault),
    .remote_fault_ff         (remote_fault_ff),
    .internal_local_fault_ff (internal_local_fault_ff),
    .received_local_fault_ff (received_local_fault_ff),
    .local_fault_ff          (local_fault_ff)
  );

  assign active = (state_ff != mpfs_pkg::MPFS_IDLE);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_send_gap_only: assert property (@(posedge clk) disable iff (rst)
    pause_send_ff |-> !$past(tx_frame_busy))
    else $error("pause issued during a frame");
  // The index is looked up through the winner of the previous cycle; the held index there is the older send
  a_send_enabled: assert property (@(posedge clk) disable iff (rst)
    pause_send_ff |-> $past(pause_enable[pick]))
    else $error("pause sent for disabled class");
  a_quanta_match: assert property (@(posedge clk) disable iff (rst)
    pause_send_ff |-> pause_quanta_ff == $past(pause_quanta[pick]))
    else $error("pause quanta not from its index");
  a_global_flag: assert property (@(posedge clk) disable iff (rst)
    pause_send_ff |-> pause_global_ff == (pause_index_ff == 4'h8))
    else $error("global flag mismatch");
  a_resend_pending: assert property (@(posedge clk) disable iff (rst)
    ce && resend_pause && (pause_req & pause_enable) != 9'h000 |=> pause_pending_ff != 9'h000 || pause_send_ff)
    else $error("resend did not mark pending");
  a_timer_reload: assert property (@(posedge clk) disable iff (rst)
    pause_send_ff && $past(ce && !resend_pause && pause_req[pick] && pause_enable[pick]) |->
      timer_ff[pause_index_ff] == $past(pause_refresh_timer[pick]))
    else $error("refresh timer not reloaded");
  a_send_pulse: assert property (@(posedge clk) disable iff (rst)
    pause_send_ff |=> !pause_send_ff)
    else $error("send held longer than one cycle");
  a_request_served: assert property (@(posedge clk) disable iff (rst)
    ce && state_ff == mpfs_pkg::MPFS_WAIT && pick_vld && !tx_frame_busy |=> pause_send_ff)
    else $error("ready request not sent");

  c_global_send: cover property (@(posedge clk) pause_send_ff && pause_global_ff);
  c_prio_send: cover property (@(posedge clk) pause_send_ff && !pause_global_ff);
  c_wait_frame: cover property (@(posedge clk) active && tx_frame_busy ##1 pause_send_ff);
  c_resend: cover property (@(posedge clk) resend_pause ##[1:20] pause_send_ff);
endmodule : mpfs_top
`default_nettype wire

// [mpfs_fmt_model.sv]
// Behavioural pause frame formatter that answers each send after a set delay
`timescale 1ns/1ps
`default_nettype none
module mpfs_fmt_model #(
  parameter int DONE_LAT = 3
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pause command and completion
  input  wire logic pause_send_ff,
  output logic      pause_done
);
  int cnt_ff;
  // A fixed latency keeps the done pulse apart from the send that caused it
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff     <= 0;
      pause_done <= 1'b0;
    end else begin
      pause_done <= (cnt_ff == 1);
      if (pause_send_ff) cnt_ff <= DONE_LAT;
      else if (cnt_ff != 0) cnt_ff <= cnt_ff - 1;
    end
  end
endmodule // mpfs_fmt_model
`default_nettype wire

// [tb.sv]
// Self-checking bench for the pause scheduler and fault status outputs
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst, ce, busy, resend, pause_done;
  logic [8:0]  req, en;
  logic [4:0]  flt;
  logic [15:0] quanta [9];
  logic [15:0] refr [9];
  logic        pause_send_ff, pause_global_ff;
  logic [3:0]  pause_index_ff;
  logic [15:0] pause_quanta_ff;
  logic [8:0]  pause_pending_ff;
  logic        rf, ilf, rlf, lf;
  int          mismatches, check_count;
  bit          seen;
  mpfs_top i_mpfs_top (.clk(clk), .rst(rst), .ce(ce), .pause_req(req), .pause_enable(en),
    .resend_pause(resend), .pause_quanta(quanta), .pause_refresh_timer(refr), .tx_frame_busy(busy),
    .pause_done(pause_done), .pause_send_ff(pause_send_ff), .pause_global_ff(pause_global_ff),
    .pause_index_ff(pause_index_ff), .pause_quanta_ff(pause_quanta_ff), .pause_pending_ff(pause_pending_ff),
    .remote_fault_det(flt[0]), .test_pattern_gen(flt[1]), .lane_align_bad(flt[2]), .hi_ber(flt[3]),
    .rx_lf_fsm_fault(flt[4]), .remote_fault_ff(rf), .internal_local_fault_ff(ilf),
    .received_local_fault_ff(rlf), .local_fault_ff(lf));
  mpfs_fmt_model i_mpfs_fmt_model (.clk(clk), .rst(rst), .pause_send_ff(pause_send_ff), .pause_done(pause_done));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) begin @(posedge clk); #1; end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    check_count++;
    if (got !== exp) begin mismatches++; $display("CHECK FAILED %0t %s", $time, msg); end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin mismatches++; $display("CHECK FAILED %0t %s", $time, msg); end
  endtask
  // Bounded wait for a send pulse, looked at in the cycle it stands
  task automatic wait_send(input int lim, output bit s);
    s = 0;
    for (int i = 0; i < lim && !s; i++) begin tick(1); s = (pause_send_ff === 1'b1); end
  endtask
  task automatic pulse_resend();
    resend = 1'b1; tick(1); resend = 1'b0;
  endtask
  // Drop requests and zero timers so every scenario starts clean
  task automatic clear();
    req = 9'h000; tick(6); pulse_resend(); tick(6);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_faults();
    for (int v = 0; v < 32; v++) begin
      flt = 5'(v); tick(2);
      chk_bit(rf, flt[0], "remote fault");
      chk_bit(ilf, |flt[3:1], "internal fault");
      chk_bit(rlf, flt[4], "received fault");
      chk_bit(lf, |flt[4:1], "local fault");
    end
    flt = 5'h00;
  endtask
  task automatic t_classes();
    for (int i = 0; i < 9; i++) begin
      clear(); req[i] = 1'b1; wait_send(10, seen);
      chk_bit(seen, 1'b1, "class not sent");
      chk_val({12'h000, pause_index_ff}, 16'(i), "index");
      chk_val(pause_quanta_ff, quanta[i], "quanta");
      chk_bit(pause_global_ff, i == 8, "global flag");
    end
  endtask
  task automatic t_enable_order();
    clear(); en = 9'h1ef; req = 9'h010; wait_send(20, seen);
    chk_bit(seen, 1'b0, "disabled class sent");
    chk_val({7'h00, pause_pending_ff}, 16'h0000, "disabled class pending");
    req = 9'h034; wait_send(10, seen);
    chk_val({12'h000, pause_index_ff}, 16'h0002, "lowest first");
    wait_send(20, seen);
    chk_val({12'h000, pause_index_ff}, 16'h0005, "second class");
    wait_send(20, seen);
    chk_bit(seen, 1'b0, "disabled class sent later");
    en = 9'h1ff;
  endtask
  task automatic t_busy_resend();
    clear(); busy = 1'b1; req = 9'h002; wait_send(30, seen);
    chk_bit(seen, 1'b0, "send inside frame");
    chk_val({7'h00, pause_pending_ff}, 16'h0002, "pending while frame");
    busy = 1'b0; wait_send(10, seen);
    chk_bit(seen, 1'b1, "send after frame");
    wait_send(20, seen);
    chk_bit(seen, 1'b0, "early resend");
    busy = 1'b1; pulse_resend(); wait_send(10, seen);
    chk_bit(seen, 1'b0, "resend inside frame");
    chk_val({7'h00, pause_pending_ff}, 16'h0002, "resend not pending");
    busy = 1'b0; wait_send(10, seen);
    chk_bit(seen, 1'b1, "resend missing");
    chk_val({12'h000, pause_index_ff}, 16'h0001, "resend index");
  endtask
  // Clock enable low must freeze status and scheduling alike; released while idle so no send is cut
  task automatic t_freeze();
    clear(); ce = 1'b0; flt = 5'h1f; req = 9'h001; tick(4);
    chk_bit(rf | lf | pause_send_ff, 1'b0, "state moved while frozen");
    chk_val({7'h00, pause_pending_ff}, 16'h0000, "pending moved while frozen");
    ce = 1'b1; wait_send(10, seen);
    chk_bit(seen, 1'b1, "send after thaw");
    chk_bit(rf & lf, 1'b1, "faults after thaw");
    flt = 5'h00; req = 9'h000;
  endtask
  task automatic t_refresh();
    clear(); refr[0] = 16'h0010; req = 9'h001; wait_send(10, seen);
    wait_send(8, seen);
    chk_bit(seen, 1'b0, "refresh too early");
    wait_send(30, seen);
    chk_bit(seen, 1'b1, "refresh missing");
    req = 9'h000; refr[0] = 16'h0100;
  endtask
  task automatic conclude();
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Run needs under 550 cycles; this leaves wide margin
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
  initial begin
    rst = 1'b1; ce = 1'b1; busy = 1'b0; resend = 1'b0; req = 9'h000; en = 9'h1ff; flt = 5'h00;
    mismatches = 0; check_count = 0;
    for (int i = 0; i < 9; i++) begin quanta[i] = 16'h1000 + 16'(i * 'h111); refr[i] = 16'h0100; end
    tick(5); rst = 1'b0; tick(1);
    chk_bit(pause_send_ff | lf | rf, 1'b0, "outputs after reset");
    chk_val({7'h00, pause_pending_ff}, 16'h0000, "pending after reset");
    t_faults();
    t_classes();
    t_enable_order();
    t_busy_resend();
    t_freeze();
    t_refresh();
    conclude();
  end
endmodule // tb
`default_nettype wire
